/* shared/perfmon_event_map.svh */
// Field positions, event codes and register offsets for event selection
`ifndef PERFMON_EVENT_MAP_SVH
`define PERFMON_EVENT_MAP_SVH
`define SEL_HI 31
`define SEL_LO 25
`define SEL_NARROW_HI 30
`define MASK_HI 24
`define MASK_LO 9
`define CFG_HI 15
`define CFG_LO 13
`define EV_PACKED64 7'h02
`define EV_PACKED128 7'h1a
`define EV_STACK_FP 7'h04
`define EV_TRACE_MISC 7'h06
`define EV_POWER 7'h13
`define EV_ROM_SWITCH 7'h05
`define EV_UOP_QUEUE 7'h09
`define EV_MISPRED_BR 7'h05
`define EV_ALL_BR 7'h04
`define EV_ALLOC_STALL 7'h01
`define EV_WC_BUF 7'h05
`define EV_B2B 7'h16
`define EV_BNR 7'h08
`define EV_SNOOP 7'h06
`define EV_RESP 7'h04
`define CFG_FP 3'h1
`define CFG_BRANCH 3'h2
`define CFG_BUS 3'h3
`define CFG_WC 3'h5
`define CFG_POWER 3'h6
`define CFG_SEQ 3'h0
`define CFG_ALLOC 3'h1
`define CFG_TRACE 3'h1
`define MB_ALL 15
`define MB_FLUSH 4
`define MB_STORE_BUF 5
`define MB_BUS_B2B 16'h007e
`define MB_BUS_BNR 16'h0007
`define MB_BUS_SNOOP 16'h00c4
`define MB_BUS_RESP 16'h0306
`define ADDR_SELECT 4'h0
`define ADDR_CONFIG 4'h1
`define ADDR_GROUP 4'h2
`define ADDR_COUNT 4'h3
`define RST_SELECT 32'h0000_0000
`define RST_CONFIG 32'h0000_0000
`endif

/* shared/perfmon_event_pkg.sv */
// Types for the event selection block
package perfmon_event_pkg;
	typedef enum logic [2:0] {
		GRP_FP,
		GRP_TRACE,
		GRP_SEQ,
		GRP_BRANCH,
		GRP_ALLOC,
		GRP_WC,
		GRP_BUS
	} group_e;
	typedef struct packed {
		logic [31:0] sel_ctl;
		logic [31:0] cfg_ctl;
		logic [2:0] group;
		logic [31:0] count;
		logic [31:0] rdata;
		logic [2:0] inc;
	} state_s;
endpackage

/* src/perfmon_event_select.sv */
// Event selection and counting for one non-retirement performance counter
//
// Decided for this implementation: the register offsets and the strobed register port.
`timescale 1ns/1ps
`include "perfmon_event_map.svh"

// Summary of operation
// - Select 02h with mask bit 15 counts each 64-bit packed integer op.
// - Select 1Ah with mask bit 15 counts each 128-bit integer op.
// - Every qualifying op of an instruction adds one count.
// - Select 04h bit 15 counts stack FP ops, not loads, stores, moves.
// - FP op events need config select 01h; counters 8-11 served.
// - Select 06h bit 4 counts trace cache flushes, two per flush.
// - Select 13h bit 0 config 06h counts every non-stopped cycle.
// - Select 05h bit 0 config 0 counts trace-to-ROM delivery switches.
// - Select 09h counts queue writes by build, deliver, ROM bits.
// - Select 05h config 02h counts mispredicted branches by type.
// - Select 04h counts all branches; bit 2 covers any call.
// - Conditional branches may recount during rebuilds or clears.
// - Select 01h bit 5 counts stalls for lack of store buffers.
// - Select 05h config 05h counts evictions: any, or no free buffer.
// - Select 16h config 03h counts back-to-back bus cycles, bits 1-6.
// - Select 08h config 03h counts bus-not-ready, bits 0-2.
// - Select 06h config 03h counts snoop hit-modified, bits 2,6,7.
// - Select 04h config 03h counts bus responses, bits 1,2,8,9.
// - Event mask sits in bits 24:9; each bit enables one sub-event.
module perfmon_event_select (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic [3:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	output logic [31:0] count_o,
	input wire logic [1:0] packed64_ops_i,
	input wire logic [1:0] packed128_ops_i,
	input wire logic [1:0] stack_fp_ops_i,
	input wire logic stack_fp_ldst_move_i,
	input wire logic trace_flush_i,
	input wire logic not_stopped_i,
	input wire logic rom_switch_i,
	input wire logic [2:0] queue_write_src_i,
	input wire logic [4:1] br_retire_type_i,
	input wire logic br_direct_call_i,
	input wire logic br_mispred_i,
	input wire logic store_buf_stall_i,
	input wire logic [1:0] wc_evict_i,
	input wire logic [15:0] bus_cond_i
);
	perfmon_event_pkg::state_s state_reg;
	perfmon_event_pkg::state_s state_next;
	logic [6:0] sel_code;
	logic [6:0] sel_narrow;
	logic [15:0] mask;
	logic [2:0] cfg;
	logic [2:0] inc;
	logic [1:0] fp_ops;

	// Configuration select matches
	logic cfg_fp_ok;
	logic cfg_trace_ok;
	logic cfg_seq_ok;
	logic cfg_branch_ok;
	logic cfg_alloc_ok;
	logic cfg_wc_ok;
	logic cfg_bus_ok;
	logic cfg_power_ok;

	// Sub-event matches against the event mask
	logic [15:0] bus_hit;
	logic [3:0] br_type_hit;
	logic [2:0] queue_hit;
	logic [1:0] wc_hit;
	logic b2b_any;
	logic bnr_any;
	logic snoop_any;
	logic resp_any;

	// Per-group increments before the group select
	logic [2:0] inc_fp;
	logic [2:0] inc_trace;
	logic [2:0] inc_seq;
	logic [2:0] inc_branch;
	logic [2:0] inc_alloc;
	logic [2:0] inc_wc;
	logic [2:0] inc_bus;

	// Field extraction from the control words
	assign sel_code = state_reg.sel_ctl[`SEL_HI:`SEL_LO];
	assign sel_narrow = {1'b0, state_reg.sel_ctl[`SEL_NARROW_HI:`SEL_LO]};
	assign mask = state_reg.sel_ctl[`MASK_HI:`MASK_LO];
	assign cfg = state_reg.cfg_ctl[`CFG_HI:`CFG_LO];

	// Stack FP ops minus the excluded data movement op
	always_comb begin
		fp_ops = stack_fp_ops_i;
		if (stack_fp_ldst_move_i && fp_ops != 2'h0) begin
			fp_ops = fp_ops - 2'h1;
		end
	end

	// Configuration select checks per event group
	assign cfg_fp_ok = (cfg == `CFG_FP);
	assign cfg_trace_ok = (cfg == `CFG_TRACE);
	assign cfg_seq_ok = (cfg == `CFG_SEQ);
	assign cfg_branch_ok = (cfg == `CFG_BRANCH);
	assign cfg_alloc_ok = (cfg == `CFG_ALLOC);
	assign cfg_wc_ok = (cfg == `CFG_WC);
	assign cfg_bus_ok = (cfg == `CFG_BUS);
	assign cfg_power_ok = (cfg == `CFG_POWER);

	// Per-bit match of bus conditions against the event mask
	for (genvar b = 0; b < 16; b++) begin : g_bus_bit
		assign bus_hit[b] = mask[b] & bus_cond_i[b];
	end

	// Sub-event matches for branch, queue and eviction sources
	assign br_type_hit = mask[4:1] & br_retire_type_i;
	assign queue_hit = mask[2:0] & queue_write_src_i;
	assign wc_hit = mask[1:0] & wc_evict_i;

	// Bus sub-events limited to the bits each event defines
	assign b2b_any = |(bus_hit & `MB_BUS_B2B);
	assign bnr_any = |(bus_hit & `MB_BUS_BNR);
	assign snoop_any = |(bus_hit & `MB_BUS_SNOOP);
	assign resp_any = |(bus_hit & `MB_BUS_RESP);

	// Floating point group: one count per qualifying op
	always_comb begin
		inc_fp = 3'h0;
		if (cfg_fp_ok && mask[`MB_ALL]) begin
			case (sel_code)
			`EV_PACKED64: inc_fp = {1'b0, packed64_ops_i};
			`EV_PACKED128: inc_fp = {1'b0, packed128_ops_i};
			`EV_STACK_FP: inc_fp = {1'b0, fp_ops};
			default: inc_fp = 3'h0;
			endcase
		end
	end

	// Trace cache group: each flush adds two
	always_comb begin
		inc_trace = 3'h0;
		if (cfg_trace_ok && sel_code == `EV_TRACE_MISC &&
			mask[`MB_FLUSH] && trace_flush_i) begin
			inc_trace = 3'h2;
		end
	end

	// Sequencer group: ROM switches and queue writes
	always_comb begin
		inc_seq = 3'h0;
		if (cfg_seq_ok && sel_code == `EV_ROM_SWITCH) begin
			inc_seq = {2'h0, mask[0] & rom_switch_i};
		end else if (cfg_seq_ok && sel_code == `EV_UOP_QUEUE) begin
			inc_seq = {2'h0, queue_hit != 3'h0};
		end
	end

	// Branch group: retiring branches by type, at most one per cycle
	always_comb begin
		inc_branch = 3'h0;
		if (cfg_branch_ok && sel_narrow == `EV_MISPRED_BR) begin
			if (br_mispred_i && br_type_hit != 4'h0) begin
				inc_branch = 3'h1;
			end
		end else if (cfg_branch_ok && sel_narrow == `EV_ALL_BR) begin
			if (br_type_hit != 4'h0 || (mask[2] && br_direct_call_i)) begin
				inc_branch = 3'h1;
			end
		end
	end

	// Allocator group: stalls for lack of store buffers
	always_comb begin
		inc_alloc = 3'h0;
		if (cfg_alloc_ok && sel_narrow == `EV_ALLOC_STALL &&
			mask[`MB_STORE_BUF] && store_buf_stall_i) begin
			inc_alloc = 3'h1;
		end
	end

	// Write-combining group: evictions by cause
	always_comb begin
		inc_wc = 3'h0;
		if (cfg_wc_ok && sel_narrow == `EV_WC_BUF && wc_hit != 2'h0) begin
			inc_wc = 3'h1;
		end
	end

	// Bus group: running cycles and bus sub-events
	always_comb begin
		inc_bus = 3'h0;
		if (cfg_power_ok && sel_code == `EV_POWER) begin
			inc_bus = {2'h0, mask[0] & not_stopped_i};
		end else if (cfg_bus_ok) begin
			case (sel_narrow)
			`EV_B2B: inc_bus = {2'h0, b2b_any};
			`EV_BNR: inc_bus = {2'h0, bnr_any};
			`EV_SNOOP: inc_bus = {2'h0, snoop_any};
			`EV_RESP: inc_bus = {2'h0, resp_any};
			default: inc_bus = 3'h0;
			endcase
		end
	end

	// Only the programmed group may reach the counter
	always_comb begin
		case (state_reg.group)
		perfmon_event_pkg::GRP_FP: begin
			inc = inc_fp;
		end
		perfmon_event_pkg::GRP_TRACE: begin
			inc = inc_trace;
		end
		perfmon_event_pkg::GRP_SEQ: begin
			inc = inc_seq;
		end
		perfmon_event_pkg::GRP_BRANCH: begin
			inc = inc_branch;
		end
		perfmon_event_pkg::GRP_ALLOC: begin
			inc = inc_alloc;
		end
		perfmon_event_pkg::GRP_WC: begin
			inc = inc_wc;
		end
		perfmon_event_pkg::GRP_BUS: begin
			inc = inc_bus;
		end
		default: begin
			inc = 3'h0;
		end
		endcase
	end

	// Register access, counting and read data
	always_comb begin
		state_next = state_reg;
		state_next.inc = inc;
		state_next.count = state_reg.count + {29'h0, state_reg.inc};
		if (wr_i) begin
			case (addr_i)
			`ADDR_SELECT: state_next.sel_ctl = wdata_i;
			`ADDR_CONFIG: state_next.cfg_ctl = wdata_i;
			`ADDR_GROUP: begin
				state_next.group = perfmon_event_pkg::group_e'(wdata_i[2:0]);
			end
			`ADDR_COUNT: state_next.count = wdata_i;
			default: state_next.sel_ctl = state_reg.sel_ctl;
			endcase
		end
		state_next.rdata = 32'h0;
		if (rd_i) begin
			case (addr_i)
			`ADDR_SELECT: state_next.rdata = state_reg.sel_ctl;
			`ADDR_CONFIG: state_next.rdata = state_reg.cfg_ctl;
			`ADDR_GROUP: state_next.rdata = {29'h0, state_reg.group};
			`ADDR_COUNT: state_next.rdata = state_reg.count;
			default: state_next.rdata = 32'h0;
			endcase
		end
	end

	// State register with synchronous reset
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			state_reg <= '{sel_ctl: `RST_SELECT, cfg_ctl: `RST_CONFIG,
				group: 3'h0, count: 32'h0, rdata: 32'h0, inc: 3'h0};
		end else begin
			state_reg <= state_next;
		end
	end

	// Outputs straight from flip-flops
	assign rdata_o = state_reg.rdata;
	assign count_o = state_reg.count;
endmodule

/* verification/perfmon_event_monitor.sv */
// Port-level checks for the event selection block
`timescale 1ns/1ps
module perfmon_event_monitor (
	input wire logic clock_i,
	input wire logic rst_b_i,
	input wire logic [3:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	input wire logic [31:0] rdata_o,
	input wire logic [31:0] count_o,
	input wire logic [1:0] packed64_ops_i,
	input wire logic trace_flush_i,
	input wire logic not_stopped_i
);
	logic [31:0] sel_reg, cfg_reg, grp_reg;
	// Shadow copies of the written controls
	always_ff @(posedge clock_i) begin
		if (!rst_b_i) begin
			sel_reg <= 32'h0;
			cfg_reg <= 32'h0;
			grp_reg <= 32'h0;
		end else if (wr_i) begin
			if (addr_i == 4'h0) sel_reg <= wdata_i;
			if (addr_i == 4'h1) cfg_reg <= wdata_i;
			if (addr_i == 4'h2) grp_reg <= wdata_i;
		end
	end
	// True when code, mask bit, config select and group all match
	function automatic logic on(input logic [6:0] c, input int b,
		input logic [2:0] f, input logic [2:0] g);
		return sel_reg[31:25] == c && sel_reg[9 + b] &&
			cfg_reg[15:13] == f && grp_reg[2:0] == g;
	endfunction
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_b_i);
	// No register writes over the two-cycle counting latency
	sequence quiet2;
		!wr_i ##1 !wr_i;
	endsequence
	AST_PACKED_ADD: assert property (on(7'h02, 15, 3'h1, 3'h0) ##0 quiet2 |=>
		count_o == $past(count_o) + 32'($past(packed64_ops_i, 2)))
		else $error("packed op count wrong");
	AST_FLUSH_TWICE: assert property (on(7'h06, 4, 3'h1, 3'h1) ##0 quiet2 |=>
		count_o == $past(count_o) + ($past(trace_flush_i, 2) ? 32'h2 : 32'h0))
		else $error("flush count wrong");
	AST_RUN_CYCLES: assert property (on(7'h13, 0, 3'h6, 3'h6) ##0 quiet2 |=>
		count_o == $past(count_o) + 32'($past(not_stopped_i, 2)))
		else $error("running cycle count wrong");
	AST_NO_SELECT: assert property (sel_reg == 32'h0 ##0 quiet2 |=>
		$stable(count_o)) else $error("count moved with no event");
	AST_RD_IDLE: assert property (!rd_i |=> rdata_o == 32'h0)
		else $error("read data outside read cycle");
	AST_RD_SEL: assert property (rd_i && addr_i == 4'h0 |=>
		rdata_o == $past(sel_reg)) else $error("select readback wrong");
	AST_RD_HOLE: assert property (rd_i && addr_i > 4'h3 |=>
		rdata_o == 32'h0) else $error("unmapped read not zero");
	AST_CNT_WR: assert property (wr_i && addr_i == 4'h3 |=>
		count_o == $past(wdata_i)) else $error("count write lost");
endmodule
bind perfmon_event_select perfmon_event_monitor mon (.clock_i, .rst_b_i,
	.addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .count_o, .packed64_ops_i,
	.trace_flush_i, .not_stopped_i);

/* verification/perfmon_event_source.sv */
// Model of the pipeline and bus event sources
`timescale 1ns/1ps
module perfmon_event_source (
	input wire logic clock_i,
	input wire logic [1:0] kind_i,
	output logic [1:0] packed64_ops_o = 2'h0,
	output logic trace_flush_o = 1'b0,
	output logic not_stopped_o = 1'b0,
	output logic [31:0] noise_o = 32'h0
);
	logic [1:0] step_reg = 2'h0;
	// Chosen event stream plus changing background on other sources
	always_ff @(posedge clock_i) begin
		step_reg <= step_reg + 2'h1;
		noise_o <= noise_o + 32'h9e37_79b1;
		packed64_ops_o <= (kind_i == 2'h1) ? step_reg : 2'h0;
		trace_flush_o <= kind_i == 2'h2 && step_reg[0];
		not_stopped_o <= kind_i == 2'h3 && step_reg != 2'h3;
	end
endmodule

/* verification/testbench.sv */
// Self-checking bench for the event selection block
`timescale 1ns/1ps
module testbench;
	logic clock_i = 1'b0, rst_b_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
	logic [3:0] addr_i = 4'h0;
	logic [31:0] wdata_i = 32'h0, rdata_o, count_o, nz, acc = 32'h0;
	logic [1:0] kind = 2'h0, p64;
	logic [31:0] ref_acc = 32'h0, ref_q = 32'h0;
	logic [3:0] mode = 4'h0;
	logic flush, run;
	int err_count = 0, num_checks = 0, cyc = 0;
	always #2 clock_i = ~clock_i;
	perfmon_event_source src (.clock_i, .kind_i(kind), .packed64_ops_o(p64),
		.trace_flush_o(flush), .not_stopped_o(run), .noise_o(nz));
	perfmon_event_select dut (.clock_i, .rst_b_i, .addr_i, .wdata_i, .wr_i,
		.rd_i, .rdata_o, .count_o, .packed64_ops_i(p64),
		.packed128_ops_i(nz[1:0]), .stack_fp_ops_i(nz[3:2]),
		.stack_fp_ldst_move_i(nz[4]), .trace_flush_i(flush),
		.not_stopped_i(run), .rom_switch_i(nz[5]),
		.queue_write_src_i(nz[8:6]), .br_retire_type_i(nz[12:9]),
		.br_direct_call_i(nz[13]), .br_mispred_i(nz[14]),
		.store_buf_stall_i(nz[15]), .wc_evict_i(nz[17:16]),
		.bus_cond_i(nz[31:16]));
	// Weighted sum of the chosen events; flushes count double
	always @(posedge clock_i) begin
		acc <= acc + 32'(p64) + (flush ? 32'h2 : 32'h0) + 32'(run);
		cyc++;
		if (cyc == 3000) begin
			err_count++;
			complete_run();
		end
	end
	// Expected counts for events fed from the background source
	always @(posedge clock_i) begin
		ref_q <= ref_acc;
		case (mode)
		4'h1: ref_acc <= ref_acc + 32'(nz[1:0]);
		4'h2: ref_acc <= ref_acc + 32'(nz[3:2])
			- 32'(nz[4] && nz[3:2] != 2'h0);
		4'h3: ref_acc <= ref_acc + 32'(nz[5]);
		4'h4: ref_acc <= ref_acc + 32'(|nz[8:6]);
		4'h5: ref_acc <= ref_acc + 32'(nz[14] && |nz[12:9]);
		4'h6: ref_acc <= ref_acc + 32'(|nz[12:9] || nz[13]);
		4'h7: ref_acc <= ref_acc + 32'(nz[15]);
		4'h8: ref_acc <= ref_acc + 32'(|nz[17:16]);
		4'h9: ref_acc <= ref_acc + 32'(|(nz[31:16] & 16'h007e));
		4'ha: ref_acc <= ref_acc + 32'(|(nz[31:16] & 16'h0007));
		4'hb: ref_acc <= ref_acc + 32'(|(nz[31:16] & 16'h00c4));
		4'hc: ref_acc <= ref_acc + 32'(|(nz[31:16] & 16'h0306));
		default: ref_acc <= ref_acc;
		endcase
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			err_count++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge clock_i);
		wr_i <= 1'b0;
	endtask
	task automatic rc(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clock_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge clock_i);
		rd_i <= 1'b0;
		#1 check(rdata_o, exp);
	endtask
	// Program an event fed by the background source, compare the counter
	task automatic trial_nz(input logic [31:0] sel, input logic [31:0] cfg,
		input logic [31:0] grp, input logic [3:0] m);
		logic [31:0] base;
		mode <= m;
		wr(4'h0, sel);
		wr(4'h1, cfg);
		wr(4'h2, grp);
		wr(4'h3, 32'h0);
		base = ref_acc;
		repeat (20) @(posedge clock_i);
		#1 check(count_o, ref_q - base);
		$display("Test done: background select %h", sel);
	endtask
	// Program one event, run the source, compare the counter
	task automatic trial(input logic [31:0] sel, input logic [31:0] cfg,
		input logic [31:0] grp, input logic [1:0] k, input logic hit);
		logic [31:0] base;
		wr(4'h0, sel);
		wr(4'h1, cfg);
		wr(4'h2, grp);
		wr(4'h3, 32'h0);
		base = acc;
		kind <= k;
		repeat (20) @(posedge clock_i);
		kind <= 2'h0;
		repeat (4) @(posedge clock_i);
		rc(4'h0, sel);
		rc(4'h3, hit ? acc - base : 32'h0);
		$display("Test done: select %h config %h", sel, cfg);
	endtask
	task automatic complete_run();
		$display("Checks %0d, mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// Reset, register defaults, then event trials
	initial begin
		repeat (6) @(posedge clock_i);
		rst_b_i <= 1'b1;
		for (int i = 0; i < 4; i++)
			rc(4'(i), 32'h0);
		wr(4'h9, 32'hffff_ffff);
		rc(4'h9, 32'h0);
		$display("Test done: reset values");
		trial(32'h0500_0000, 32'h2000, 32'h0, 2'h1, 1'b1);
		trial(32'h0500_0000, 32'h4000, 32'h0, 2'h1, 1'b0);
		trial(32'h0480_0000, 32'h2000, 32'h0, 2'h1, 1'b0);
		trial(32'h0c00_2000, 32'h2000, 32'h1, 2'h2, 1'b1);
		trial(32'h2600_0200, 32'hc000, 32'h6, 2'h3, 1'b1);
		trial_nz(32'h3500_0000, 32'h2000, 32'h0, 4'h1);
		trial_nz(32'h3500_0000, 32'h2000, 32'h1, 4'h0);
		trial_nz(32'h0900_0000, 32'h2000, 32'h0, 4'h2);
		trial_nz(32'h0a00_0200, 32'h0000, 32'h2, 4'h3);
		trial_nz(32'h1200_0e00, 32'h0000, 32'h2, 4'h4);
		trial_nz(32'h0a00_3c00, 32'h4000, 32'h3, 4'h5);
		trial_nz(32'h0800_3c00, 32'h4000, 32'h3, 4'h6);
		trial_nz(32'h0200_4000, 32'h2000, 32'h4, 4'h7);
		trial_nz(32'h0a00_0600, 32'ha000, 32'h5, 4'h8);
		trial_nz(32'h2dff_fe00, 32'h6000, 32'h6, 4'h9);
		trial_nz(32'h11ff_fe00, 32'h6000, 32'h6, 4'ha);
		trial_nz(32'h0dff_fe00, 32'h6000, 32'h6, 4'hb);
		trial_nz(32'h09ff_fe00, 32'h6000, 32'h6, 4'hc);
		complete_run();
	end
endmodule
